// file: shared/sacc_pkg.sv
// constants, types and helpers shared by the converter control block
package sacc_pkg;

  // ----------------------------------------------------------------
  // register addresses on the special function register port
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'hbc;
  localparam logic [7:0] ADDR_RES_LO = 8'hbd;
  localparam logic [7:0] ADDR_RES_HI = 8'hbe;
  localparam logic [7:0] ADDR_CTL = 8'he8;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RESET = 8'hf8;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] RES_RESET = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_DIV_LSB = 3;
  localparam int CFG_LJ_BIT = 2;
  localparam int CTL_EN_BIT = 7;
  localparam int CTL_TM_BIT = 6;
  localparam int CTL_INT_BIT = 5;
  localparam int CTL_BUSY_BIT = 4;
  localparam int CTL_WIN_BIT = 3;
  localparam int CTL_CM_LSB = 0;

  // ----------------------------------------------------------------
  // cycle counts in sar clocks
  // ----------------------------------------------------------------
  localparam logic [3:0] TRACK_SAR_CLKS = 4'h3;
  localparam logic [3:0] CONV_SAR_CLKS = 4'hb;

  // mux code of the temperature sensor on the positive input
  localparam logic [5:0] MUX_TEMP_SENSOR = 6'h1e;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    sm_soft = 3'b000,
    sm_t0 = 3'b001,
    sm_t2 = 3'b010,
    sm_t1 = 3'b011,
    sm_ext = 3'b100,
    sm_t3 = 3'b101,
    sm_t4 = 3'b110,
    sm_t5 = 3'b111
  } sacc_start_mode_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_track = 2'b01,
    st_conv = 2'b10
  } sacc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sacc_sfr_req_t;

  // index 0..3 of the split arrays stands for timers 2..5
  typedef struct packed {
    logic t0_ovf;
    logic t1_ovf;
    logic [3:0] lo_ovf;
    logic [3:0] hi_ovf;
    logic [3:0] split8;
  } sacc_timer_evt_t;

  // ----------------------------------------------------------------
  // result placement in the high:low register pair
  // ----------------------------------------------------------------
  function automatic logic [15:0] sacc_format(
    input logic [9:0] code,
    input logic lj,
    input logic eight,
    input logic diff
  );
    logic [15:0] r;
    r = {6'h00, code};
    if (eight) begin
      r = {8'h00, code[9:2]};
    end else if (lj) begin
      r = {code, 6'h00};
    end else if (diff) begin
      r = {{6{code[9]}}, code};
    end
    return r;
  endfunction

endpackage

// file: src/sacc_clkdiv.sv
// sar clock enable divider: one tick every (div + 1) system clocks
`timescale 1ns/1ps
module sacc_clkdiv
  import sacc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] div,
  output logic tick_q
);

  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic wrap;

  assign wrap = (cnt_q >= div);
  assign cnt_d = wrap ? 5'h00 : 5'(cnt_q + 5'h01);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= 5'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= wrap;
    end
  end

endmodule

// file: src/sacc_top.sv
// conversion control of the 10-bit sar converter
//
// Overview of operation
// - sar clock is system clock over divider+1
// - start only from the selected source
// - software busy write launches one conversion
// - busy stays high for the whole conversion
// - busy falling at completion sets flag, raises interrupt request
// - result registers loaded in the cycle a completion sets flag
// - timers 2-5 use low or high overflow
// - normal mode tracks idle, converts at once
// - low-power mode adds three sar clocks tracking
// - external start low-power: track while pin low
// - justify bit picks right or left alignment, except in eight-bit mode (always right)
// - temperature sensor routed to positive input
// - disabled converter ignores starts, stays shut down
// - external start pin gets no tracking delay
`timescale 1ns/1ps
module sacc_top
  import sacc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire sacc_sfr_req_t sfr,
  output logic [7:0] sfr_rdata_q,
  input wire sacc_timer_evt_t timers,
  input wire logic external_start_input,
  input wire logic [9:0] conv_code,
  input wire logic eight_bit_mode_enable,
  input wire logic differential_mode,
  input wire logic [5:0] positive_mux_select_field,
  input wire logic irq_enable,
  output logic sar_tick_q,
  output logic track_q,
  output logic converting_q,
  output logic irq_request_q,
  output logic temp_sensor_route_q,
  output logic converter_enable_q
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [4:0] sar_clock_divider_q;
  logic left_justify_select_q;
  logic [1:0] cfg_rsv_q;
  logic track_mode_select_q;
  logic conversion_complete_flag_q;
  logic conversion_busy_q;
  logic window_flag_q;
  sacc_start_mode_t start_mode_select_q;
  logic [7:0] result_high_byte_q;
  logic [7:0] result_low_byte_q;
  sacc_state_t state_q;
  sacc_state_t state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic wr_cfg;
  logic wr_ctl;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] cfg_rd;
  logic [7:0] ctl_rd;
  logic [7:0] rd_mux;

  assign wr_cfg = sfr.wr && (sfr.addr == ADDR_CFG);
  assign wr_ctl = sfr.wr && (sfr.addr == ADDR_CTL);
  assign wr_lo = sfr.wr && (sfr.addr == ADDR_RES_LO);
  assign wr_hi = sfr.wr && (sfr.addr == ADDR_RES_HI);

  assign cfg_rd = {sar_clock_divider_q, left_justify_select_q, cfg_rsv_q};
  assign ctl_rd = {converter_enable_q, track_mode_select_q,
                   conversion_complete_flag_q, conversion_busy_q,
                   window_flag_q, start_mode_select_q};

  assign rd_mux = (sfr.addr == ADDR_CFG) ? cfg_rd :
                  (sfr.addr == ADDR_CTL) ? ctl_rd :
                  (sfr.addr == ADDR_RES_LO) ? result_low_byte_q :
                  (sfr.addr == ADDR_RES_HI) ? result_high_byte_q :
                  8'h00;

  // ----------------------------------------------------------------
  // sar clock divider
  // ----------------------------------------------------------------
  sacc_clkdiv u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .div(sar_clock_divider_q),
    .tick_q(sar_tick_q)
  );

  // ----------------------------------------------------------------
  // start source selection
  // ----------------------------------------------------------------
  logic [3:0] split_ovf;
  logic ext_rise;
  logic sw_start;
  logic src_hit;
  logic ready;
  logic start_evt;

  // 8-bit timers overflow on the low byte, 16-bit ones on the high
  assign split_ovf = (timers.split8 & timers.lo_ovf) |
                     (~timers.split8 & timers.hi_ovf);
  assign ext_rise = ext_s2_q && !ext_s3_q;
  assign sw_start = wr_ctl && sfr.wdata[CTL_BUSY_BIT];

  assign src_hit =
    (start_mode_select_q == sm_soft) ? sw_start :
    (start_mode_select_q == sm_t0) ? timers.t0_ovf :
    (start_mode_select_q == sm_t1) ? timers.t1_ovf :
    (start_mode_select_q == sm_t2) ? split_ovf[0] :
    (start_mode_select_q == sm_t3) ? split_ovf[1] :
    (start_mode_select_q == sm_t4) ? split_ovf[2] :
    (start_mode_select_q == sm_t5) ? split_ovf[3] :
    ext_rise;

  assign ready = (state_q == st_idle) && !conversion_busy_q;
  assign start_evt = converter_enable_q && ready && src_hit;

  // ----------------------------------------------------------------
  // track and convert sequencing
  // ----------------------------------------------------------------
  logic track_last;
  logic conv_last;
  logic done;
  logic delayed;

  assign track_last = sar_tick_q && (cnt_q == 4'(TRACK_SAR_CLKS - 4'h1));
  assign conv_last = sar_tick_q && (cnt_q == 4'(CONV_SAR_CLKS - 4'h1));
  assign done = (state_q == st_conv) && conv_last;
  // the external pin already tracked while low, so it gets no delay
  assign delayed = track_mode_select_q &&
                   (start_mode_select_q != sm_ext);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      st_idle: begin
        cnt_d = 4'h0;
        if (start_evt) begin
          state_d = delayed ? st_track : st_conv;
        end
      end
      st_track: begin
        if (sar_tick_q) begin
          cnt_d = 4'(cnt_q + 4'h1);
        end
        if (track_last) begin
          state_d = st_conv;
          cnt_d = 4'h0;
        end
      end
      st_conv: begin
        if (sar_tick_q) begin
          cnt_d = 4'(cnt_q + 4'h1);
        end
        if (conv_last) begin
          state_d = st_idle;
          cnt_d = 4'h0;
        end
      end
      default: begin
        state_d = st_idle;
        cnt_d = 4'h0;
      end
    endcase
    if (!converter_enable_q) begin
      state_d = st_idle;
      cnt_d = 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // outputs toward the analog core
  // ----------------------------------------------------------------
  logic track_d;
  logic idle_track;
  logic [15:0] fmt;

  assign idle_track = !track_mode_select_q ? 1'b1 :
                      (start_mode_select_q == sm_ext) ? !ext_s2_q :
                      1'b0;
  assign track_d = converter_enable_q &&
                   ((state_d == st_track) ||
                    ((state_d == st_idle) && idle_track));
  assign fmt = sacc_format(conv_code, left_justify_select_q,
                           eight_bit_mode_enable, differential_mode);

  // ----------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= external_start_input;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= st_idle;
      cnt_q <= 4'h0;
      track_q <= 1'b0;
      converting_q <= 1'b0;
      temp_sensor_route_q <= 1'b0;
      irq_request_q <= 1'b0;
      sfr_rdata_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      track_q <= track_d;
      converting_q <= (state_d == st_conv);
      temp_sensor_route_q <=
        (positive_mux_select_field == MUX_TEMP_SENSOR);
      irq_request_q <= conversion_complete_flag_q && irq_enable;
      sfr_rdata_q <= sfr.rd ? rd_mux : sfr_rdata_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {sar_clock_divider_q, left_justify_select_q, cfg_rsv_q} <= CFG_RESET;
    end else if (wr_cfg) begin
      sar_clock_divider_q <= sfr.wdata[CFG_DIV_LSB +: 5];
      left_justify_select_q <= sfr.wdata[CFG_LJ_BIT];
      cfg_rsv_q <= sfr.wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {converter_enable_q, track_mode_select_q, conversion_complete_flag_q,
       conversion_busy_q, window_flag_q} <= CTL_RESET[7:3];
      start_mode_select_q <= sacc_start_mode_t'(CTL_RESET[CTL_CM_LSB +: 3]);
    end else begin
      if (wr_ctl) begin
        converter_enable_q <= sfr.wdata[CTL_EN_BIT];
        track_mode_select_q <= sfr.wdata[CTL_TM_BIT];
        window_flag_q <= sfr.wdata[CTL_WIN_BIT];
        start_mode_select_q <=
          sacc_start_mode_t'(sfr.wdata[CTL_CM_LSB +: 3]);
      end
      // a completion in the same cycle as a clear still sets the flag
      if (done) begin
        conversion_complete_flag_q <= 1'b1;
      end else if (wr_ctl) begin
        conversion_complete_flag_q <= sfr.wdata[CTL_INT_BIT];
      end
      if (!converter_enable_q || done) begin
        conversion_busy_q <= 1'b0;
      end else if (start_evt) begin
        conversion_busy_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_high_byte_q <= RES_RESET;
      result_low_byte_q <= RES_RESET;
    end else if (done) begin
      result_high_byte_q <= fmt[15:8];
      result_low_byte_q <= fmt[7:0];
    end else begin
      if (wr_hi) begin
        result_high_byte_q <= sfr.wdata;
      end
      if (wr_lo) begin
        result_low_byte_q <= sfr.wdata;
      end
    end
  end

endmodule

// file: verification/sacc_far_side.sv
// timer and start pin model facing the converter control
`timescale 1ns/1ps
module sacc_far_side
  import sacc_pkg::*;
#(
  parameter logic [9:0] VAL = 10'h000
)
(
  input wire logic clk,
  output sacc_timer_evt_t timers,
  output logic external_start_input,
  output logic [9:0] conv_code
);
  // timers 2 and 4 run 8-bit, 3 and 5 run 16-bit
  initial begin
    timers = '0;
    timers.split8 = 4'b0101;
    external_start_input = 1'b0;
    conv_code = VAL;
  end

  // one event pulse per call (timers 0 and 1 both for source 4 without ok), a start from source m only when ok is set; caller waits for completion
  task automatic fire(input logic [2:0] m, input logic ok);
    int i;
    i = (m == 3'd2) ? 0 : int'(m) - 4;
    @(posedge clk);
    #1;
    if (m == 3'd4 && ok) begin
      external_start_input = 1'b1;
    end else if (m == 3'd1 || m == 3'd3 || m == 3'd4) begin
      timers.t0_ovf = (m == 3'd1) == ok;
      timers.t1_ovf = (m == 3'd3) == ok;
    end else if (timers.split8[i] == ok) begin
      timers.lo_ovf[i] = 1'b1;
    end else begin
      timers.hi_ovf[i] = 1'b1;
    end
    @(posedge clk);
    #1;
    timers = {2'b00, 8'h00, timers.split8};
    external_start_input = 1'b0;
  endtask
endmodule

// file: verification/sacc_top_asserts.sv
// port assertions of the converter control block
`timescale 1ns/1ps
module sacc_top_asserts
  import sacc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire sacc_sfr_req_t sfr,
  input wire logic [5:0] positive_mux_select_field,
  input wire logic irq_enable,
  input wire logic sar_tick_q,
  input wire logic track_q,
  input wire logic converting_q,
  input wire logic irq_request_q,
  input wire logic temp_sensor_route_q,
  input wire logic converter_enable_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  tick_gap_a: assert property (
    sar_tick_q |-> ##[1:32] sar_tick_q) else $error("tick gap");
  conv_hold_a: assert property (
    $rose(converting_q) |-> converting_q [*8]) else $error("short conv");
  conv_len_a: assert property (
    $rose(converting_q) |-> ##[8:360] !converting_q) else $error("long conv");
  irq_raise_a: assert property (
    $fell(converting_q) && converter_enable_q && irq_enable
    |=> irq_request_q) else $error("no irq");
  irq_mask_a: assert property (
    !irq_enable |=> !irq_request_q) else $error("masked irq");
  no_overlap_a: assert property (
    !(track_q && converting_q)) else $error("track in conv");
  off_idle_a: assert property (
    !converter_enable_q [*2] |-> !converting_q) else $error("conv off");
  en_write_a: assert property (
    sfr.wr && sfr.addr == ADDR_CTL
    |=> converter_enable_q == $past(sfr.wdata[CTL_EN_BIT]))
    else $error("enable bit");
  temp_route_a: assert property (
    temp_sensor_route_q ==
    $past(positive_mux_select_field == MUX_TEMP_SENSOR))
    else $error("temp route");
  c_irq: cover property ($rose(irq_request_q));
  c_end: cover property ($fell(converting_q));
  c_temp: cover property ($rose(temp_sensor_route_q));
endmodule

bind sacc_top sacc_top_asserts i_chk (
  .clk(clk), .sys_rst(sys_rst), .sfr(sfr),
  .positive_mux_select_field(positive_mux_select_field),
  .irq_enable(irq_enable), .sar_tick_q(sar_tick_q),
  .track_q(track_q), .converting_q(converting_q),
  .irq_request_q(irq_request_q),
  .temp_sensor_route_q(temp_sensor_route_q),
  .converter_enable_q(converter_enable_q));

// file: verification/sar_adc_conversion_control_tb.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
module sar_adc_conversion_control_tb;
  import sacc_pkg::*;
  localparam logic [9:0] CODE = 10'h2a5;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  sacc_sfr_req_t sfr = '0;
  logic [5:0] mux = 6'h00;
  logic irq_en = 1'b1;
  logic lj = 1'b0;
  logic eight = 1'b0;
  logic [7:0] rdata, v;
  logic tick, trk, cnv, irq, tmp, en, pin;
  sacc_timer_evt_t timers;
  logic [9:0] code;
  int n_mismatch = 0;
  int compares = 0;
  int t;

  always #25 clk = ~clk;

  sacc_far_side #(.VAL(CODE)) i_far (.clk(clk), .timers(timers),
    .external_start_input(pin), .conv_code(code));
  sacc_top i_dut (.clk(clk), .sys_rst(sys_rst), .sfr(sfr),
    .sfr_rdata_q(rdata), .timers(timers), .external_start_input(pin),
    .conv_code(code), .eight_bit_mode_enable(eight),
    .differential_mode(1'b0), .positive_mux_select_field(mux),
    .irq_enable(irq_en), .sar_tick_q(tick), .track_q(trk),
    .converting_q(cnv), .irq_request_q(irq),
    .temp_sensor_route_q(tmp), .converter_enable_q(en));

  // ----------------------------------------------------------------
  // checking and access tasks
  // ----------------------------------------------------------------
  task automatic results();
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic limit(input int n);
    if (t >= n) begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    #1;
    sfr = '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    #1;
    sfr.wr = 1'b0;
    sfr.rd = 1'b0;
    v = rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(v, e);
  endtask
  task automatic step();
    @(posedge clk);
    #1;
    t++;
  endtask
  task automatic next_tick();
    t = 0;
    do step(); while (!tick && t < 40);
    limit(40);
  endtask

  // one conversion from source m, checked end to end
  task automatic run(input logic [2:0] m, input logic lp);
    logic [15:0] e;
    int k;
    k = 0;
    e = eight ? {8'h00, CODE[9:2]} : lj ? {CODE, 6'h00} : {6'h00, CODE};
    acc(1'b1, ADDR_CTL, {1'b1, lp, 3'b000, m});
    if (m != 3'd0) begin
      i_far.fire(m, 1'b0);
      repeat (8) step();
      chkb(cnv, 1'b0);
      if (m == 3'd4) chkb(trk, 1'b1);
      i_far.fire(m, 1'b1);
    end else begin
      acc(1'b1, ADDR_CTL, {1'b1, lp, 3'b010, m});
    end
    t = 0;
    while (!cnv && t < 99) begin
      step();
      k += int'(trk);
    end
    limit(99);
    if (lp && m != 3'd4) begin
      chkb(k >= 4 && k <= 7, 1'b1);
    end else begin
      chkb(k <= (m == 3'd4 ? 3 : 0), 1'b1);
    end
    acc(1'b0, ADDR_CTL, 8'h00);
    chkb(v[CTL_BUSY_BIT], 1'b1);
    t = 0;
    v = 8'h00;
    while (!v[CTL_INT_BIT] && t < 99) begin
      acc(1'b0, ADDR_CTL, 8'h00);
      t++;
    end
    limit(99);
    chk(v, {1'b1, lp, 3'b100, m});
    chkb(irq, irq_en);
    rdc(ADDR_RES_HI, e[15:8]);
    rdc(ADDR_RES_LO, e[7:0]);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    rdc(ADDR_CFG, CFG_RESET);
    rdc(ADDR_CTL, CTL_RESET);
    rdc(ADDR_RES_LO, RES_RESET);
    rdc(8'h00, 8'h00);
    acc(1'b1, ADDR_CFG, 8'h08);
    rdc(ADDR_CFG, 8'h08);
    next_tick();
    next_tick();
    step();
    chkb(tick, 1'b0);
    step();
    chkb(tick, 1'b1);
    acc(1'b1, ADDR_CTL, 8'h10);
    repeat (30) step();
    chkb(cnv, 1'b0);
    rdc(ADDR_CTL, 8'h00);
    acc(1'b1, ADDR_CTL, 8'h80);
    chkb(en, 1'b1);
    step();
    chkb(trk, 1'b1);
    run(3'd0, 1'b0);
    lj = 1'b1;
    acc(1'b1, ADDR_CFG, 8'h0c);
    run(3'd0, 1'b0);
    eight = 1'b1;
    run(3'd0, 1'b0);
    eight = 1'b0;
    irq_en = 1'b0;
    for (int m = 0; m < 8; m++) run(m[2:0], 1'b1);
    mux = MUX_TEMP_SENSOR;
    repeat (2) step();
    chkb(tmp, 1'b1);
    mux = 6'h1d;
    repeat (2) step();
    chkb(tmp, 1'b0);
    results();
  end
endmodule
